// file: core/aips_top.sv
// parameter record decoding, per-channel scaling, limit and wire-break logic
// assumes a host writing the byte record and reading the input area, and an
// analog front end presenting signed samples and raw open-wire indications
`timescale 1ns/1ps
`include "aips_regs.svh"

module aips_top (
    // clock and reset
    input  wire logic          ref_clk,
    input  wire logic          rst_n,
    // parameter record access
    input  wire logic          param_wr,
    input  wire logic          param_rd,
    input  wire logic [4:0]    param_addr,
    input  wire logic [7:0]    param_wdata,
    output logic      [7:0]    param_rdata,
    // input area read
    input  wire logic          in_rd,
    input  wire logic [2:0]    in_addr,
    output logic      [15:0]   in_rdata,
    // analog front end
    input  wire logic [3:0]    sample_valid,
    input  wire logic [95:0]   sample_raw,
    input  wire logic [3:0]    open_wire_detect,
    // decoded configuration to the front end
    output logic      [3:0]    channel_active,
    output logic      [7:0]    temperature_unit,
    output logic      [7:0]    mains_rejection,
    // status
    output logic      [3:0]    open_wire,
    output logic      [3:0]    limit_over,
    output logic      [3:0]    limit_under,
    output logic               diag_irq
);
    logic [7:0]  diag_interrupt_enable;
    logic [7:0]  open_wire_enable;
    logic [7:0]  limit_watch_enable;
    logic [7:0]  temperature_unit_select;
    logic [7:0]  mains_reject_select;
    logic [3:0][7:0]  channel_function_code;
    logic [3:0][7:0]  function_option;
    logic [3:0][15:0] upper_limit_value;
    logic [3:0][15:0] lower_limit_value;
    logic [3:0][15:0] value;
    logic [3:0]       is_temp;
    logic [3:0]       next_open_wire;
    logic [3:0][4:0]  ch_base;
    logic [7:0]       next_param_rdata;

    // header bytes
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            diag_interrupt_enable   <= `AIPS_RST_DIAG;
            open_wire_enable        <= `AIPS_RST_OPEN_WIRE;
            limit_watch_enable      <= `AIPS_RST_LIMIT;
            temperature_unit_select <= `AIPS_RST_TEMP_UNIT;
            mains_reject_select     <= `AIPS_RST_MAINS;
        end else if (param_wr) begin
            case (param_addr)
                `AIPS_OFS_DIAG:      diag_interrupt_enable   <= param_wdata;
                `AIPS_OFS_OPEN_WIRE: open_wire_enable        <= param_wdata;
                `AIPS_OFS_LIMIT:     limit_watch_enable      <= param_wdata;
                `AIPS_OFS_TEMP_UNIT: temperature_unit_select <= param_wdata;
                `AIPS_OFS_MAINS:     mains_reject_select     <= param_wdata;
                default: ;
            endcase
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < 4; ch++) begin : g_ch
            aips_pkg::aips_range_type range;
            logic                     format_b;
            logic [7:0]               fn;
            logic [1:0]               rej;
            logic signed [15:0]       sv;

            assign ch_base[ch] = 5'(`AIPS_OFS_CH_BASE + ch * `AIPS_CH_STRIDE);
            assign fn = channel_function_code[ch];

            always_ff @(posedge ref_clk) begin
                if (!rst_n) begin
                    channel_function_code[ch] <= `AIPS_RST_FN;
                    function_option[ch]       <= `AIPS_RST_FO;
                    upper_limit_value[ch]     <= `AIPS_RST_UPPER;
                    lower_limit_value[ch]     <= `AIPS_RST_LOWER;
                end else if (param_wr) begin
                    case (param_addr - ch_base[ch])
                        5'(`AIPS_CH_FN):    channel_function_code[ch]    <= param_wdata;
                        5'(`AIPS_CH_FO):    function_option[ch]          <= param_wdata;
                        5'(`AIPS_CH_UL_HI): upper_limit_value[ch][15:8]  <= param_wdata;
                        5'(`AIPS_CH_UL_LO): upper_limit_value[ch][7:0]   <= param_wdata;
                        5'(`AIPS_CH_LL_HI): lower_limit_value[ch][15:8]  <= param_wdata;
                        5'(`AIPS_CH_LL_LO): lower_limit_value[ch][7:0]   <= param_wdata;
                        default: ;
                    endcase
                end
            end

            always_comb begin
                format_b = 1'b0;
                case (fn)
                    `AIPS_FN_OFF:    range = aips_pkg::AIPS_RANGE_OFF;
                    `AIPS_FN_U10_A:  range = aips_pkg::AIPS_RANGE_UNI10;
                    `AIPS_FN_B10_A:  range = aips_pkg::AIPS_RANGE_BIP10;
                    `AIPS_FN_MV80_A: range = aips_pkg::AIPS_RANGE_BIP80M;
                    `AIPS_FN_U10_B: begin
                        range    = aips_pkg::AIPS_RANGE_UNI10;
                        format_b = 1'b1;
                    end
                    `AIPS_FN_B10_B: begin
                        range    = aips_pkg::AIPS_RANGE_BIP10;
                        format_b = 1'b1;
                    end
                    `AIPS_FN_MV80_B: begin
                        range    = aips_pkg::AIPS_RANGE_BIP80M;
                        format_b = 1'b1;
                    end
                    default: begin
                        if (fn >= `AIPS_FN_TEMP_LO && fn <= `AIPS_FN_TEMP_HI) begin
                            range = aips_pkg::AIPS_RANGE_TEMP;
                        end else begin
                            range = aips_pkg::AIPS_RANGE_OTHER;
                        end
                    end
                endcase
            end

            assign is_temp[ch]        = (range == aips_pkg::AIPS_RANGE_TEMP);
            assign channel_active[ch] = (range != aips_pkg::AIPS_RANGE_OFF);
            assign temperature_unit[2*ch +: 2] = temperature_unit_select[2*ch +: 2];
            assign rej = mains_reject_select[2*ch +: 2];
            // no rejection off on temperature inputs
            assign mains_rejection[2*ch +: 2] =
                (is_temp[ch] && rej == `AIPS_MAINS_OFF) ? `AIPS_MAINS_DEFAULT : rej;

            assign next_open_wire[ch] = open_wire_enable[ch] & is_temp[ch]
                                        & open_wire_detect[ch];

            aips_scaler u_scaler (
                .ref_clk      (ref_clk),
                .rst_n        (rst_n),
                .sample_valid (sample_valid[ch]),
                .sample_raw   (sample_raw[24*ch +: 24]),
                .range        (range),
                .format_b     (format_b),
                .value        (value[ch])
            );

            assign sv = value[ch];

            always_ff @(posedge ref_clk) begin
                if (!rst_n) begin
                    limit_over[ch]  <= 1'b0;
                    limit_under[ch] <= 1'b0;
                end else begin
                    limit_over[ch]  <= limit_watch_enable[ch] && channel_active[ch]
                                       && (sv > $signed(upper_limit_value[ch]));
                    limit_under[ch] <= limit_watch_enable[ch] && channel_active[ch]
                                       && (sv < $signed(lower_limit_value[ch]));
                end
            end
        end
    endgenerate

    // wire-break status and diagnostic interrupt
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            open_wire <= 4'h0;
            diag_irq  <= 1'b0;
        end else begin
            open_wire <= next_open_wire;
            diag_irq  <= (diag_interrupt_enable == `AIPS_DIAG_ON)
                         && |(next_open_wire & ~open_wire);
        end
    end

    // parameter readback; reserved bytes read zero
    always_comb begin
        next_param_rdata = 8'h00;
        case (param_addr)
            `AIPS_OFS_DIAG:      next_param_rdata = diag_interrupt_enable;
            `AIPS_OFS_OPEN_WIRE: next_param_rdata = open_wire_enable;
            `AIPS_OFS_LIMIT:     next_param_rdata = limit_watch_enable;
            `AIPS_OFS_TEMP_UNIT: next_param_rdata = temperature_unit_select;
            `AIPS_OFS_MAINS:     next_param_rdata = mains_reject_select;
            default: begin
                for (int i = 0; i < 4; i++) begin
                    case (param_addr - ch_base[i])
                        5'(`AIPS_CH_FN):    next_param_rdata = channel_function_code[i];
                        5'(`AIPS_CH_FO):    next_param_rdata = function_option[i];
                        5'(`AIPS_CH_UL_HI): next_param_rdata = upper_limit_value[i][15:8];
                        5'(`AIPS_CH_UL_LO): next_param_rdata = upper_limit_value[i][7:0];
                        5'(`AIPS_CH_LL_HI): next_param_rdata = lower_limit_value[i][15:8];
                        5'(`AIPS_CH_LL_LO): next_param_rdata = lower_limit_value[i][7:0];
                        default: ;
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            param_rdata <= 8'h00;
        end else if (param_rd) begin
            param_rdata <= next_param_rdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            in_rdata <= 16'h0000;
        end else if (in_rd) begin
            in_rdata <= value[in_addr[2:1]];
        end
    end
endmodule

// file: core/aips_regs.svh
// constant offsets, field positions, reset values and scaling limits for the
// analog input parameter and scaling block; assumes a byte-wide parameter record
//
// Contract
// - diagnostic byte 00h disables interrupt, 40h enables it.
// - wire-break byte bits 0..3 enable channels 0..3; bits 7..4 reserved.
// - wire-break detection only on resistance-thermometer or thermocouple channels.
// - limit byte bits 0..3 enable monitoring on channels 0..3; bits 7..4 reserved.
// - mains rejection two bits per channel: 00 off, 01 60Hz, 10 50Hz, 11 reserved.
// - temperature channels cannot switch rejection off; default code used instead.
// - function code FFh deactivates the channel.
// - codes 10h/20h 0..10V, 12h/22h +-10V, 11h/21h +-80mV; first 27648, second 16384.
// - 27648 format: over 32511, unipolar under -4864, bipolar -27648 down to -32512.
// - 16384 format: over 20480, unipolar under -3277, bipolar -16384 down to -20480.
// - 80mV range scales linearly to full scale, limits as bipolar 10V.
// - each channel has upper limit default 7FFFh and lower limit default 8000h.
// - channel values read as two bytes at +0, +2, +4, +6.
`ifndef AIPS_REGS_SVH
`define AIPS_REGS_SVH

// parameter record byte offsets
`define AIPS_OFS_DIAG        5'h00
`define AIPS_OFS_OPEN_WIRE   5'h01
`define AIPS_OFS_LIMIT       5'h02
`define AIPS_OFS_TEMP_UNIT   5'h04
`define AIPS_OFS_MAINS       5'h05
`define AIPS_OFS_CH_BASE     5'h08
`define AIPS_CH_STRIDE       5'h06
// byte positions within a channel group
`define AIPS_CH_FN           3'h0
`define AIPS_CH_FO           3'h1
`define AIPS_CH_UL_HI        3'h2
`define AIPS_CH_UL_LO        3'h3
`define AIPS_CH_LL_HI        3'h4
`define AIPS_CH_LL_LO        3'h5

// reset values
`define AIPS_RST_DIAG        8'h00
`define AIPS_RST_OPEN_WIRE   8'h00
`define AIPS_RST_LIMIT       8'h00
`define AIPS_RST_TEMP_UNIT   8'h00
`define AIPS_RST_MAINS       8'h02
`define AIPS_RST_FN          8'h10
`define AIPS_RST_FO          8'h02
`define AIPS_RST_UPPER       16'h7FFF
`define AIPS_RST_LOWER       16'h8000

// codes
`define AIPS_DIAG_ON         8'h40
`define AIPS_MAINS_OFF       2'h0
`define AIPS_MAINS_DEFAULT   2'h2
`define AIPS_FN_OFF          8'hFF
`define AIPS_FN_U10_A        8'h10
`define AIPS_FN_U10_B        8'h20
`define AIPS_FN_B10_A        8'h12
`define AIPS_FN_B10_B        8'h22
`define AIPS_FN_MV80_A       8'h11
`define AIPS_FN_MV80_B       8'h21
`define AIPS_FN_TEMP_LO      8'h50
`define AIPS_FN_TEMP_HI      8'hBF

// front end sample: signed, nominal full scale at 2^22
`define AIPS_RAW_SHIFT       22
`define AIPS_FS_A            16'h6C00
`define AIPS_OVER_A          16'h7EFF
`define AIPS_UNDER_UNI_A     16'hED00
`define AIPS_UNDER_BIP_A     16'h8100
`define AIPS_FS_B            16'h4000
`define AIPS_OVER_B          16'h5000
`define AIPS_UNDER_UNI_B     16'hF333
`define AIPS_UNDER_BIP_B     16'hB000
`define AIPS_VALUE_OFF       16'h0000

`endif

// file: core/aips_pkg.sv
// types shared by the analog input parameter and scaling block
// assumes aips_regs.svh supplies the numeric constants
package aips_pkg;
    typedef enum logic [2:0] {
        AIPS_RANGE_OFF,
        AIPS_RANGE_UNI10,
        AIPS_RANGE_BIP10,
        AIPS_RANGE_BIP80M,
        AIPS_RANGE_TEMP,
        AIPS_RANGE_OTHER
    } aips_range_type;

    typedef logic signed [23:0] aips_raw_type;
endpackage

// file: core/aips_scaler.sv
// one channel of result scaling and clamping into the 16-bit value word
// assumes the front end delivers samples with nominal full scale at 2^22
`timescale 1ns/1ps
`include "aips_regs.svh"

module aips_scaler (
    // clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    rst_n,
    // sample in
    input  wire logic                    sample_valid,
    input  wire aips_pkg::aips_raw_type  sample_raw,
    // decoded configuration
    input  wire aips_pkg::aips_range_type range,
    input  wire logic                    format_b,
    // scaled value
    output logic [15:0]                  value
);
    logic signed [40:0] product;
    logic signed [40:0] scaled;
    logic signed [40:0] over_lim;
    logic signed [40:0] under_lim;
    logic [15:0]        full_scale;
    logic [15:0]        next_value;

    always_comb begin
        full_scale = format_b ? `AIPS_FS_B : `AIPS_FS_A;
        over_lim   = 41'($signed(`AIPS_OVER_A));
        under_lim  = (range == aips_pkg::AIPS_RANGE_UNI10) ? 41'($signed(`AIPS_UNDER_UNI_A))
                                                            : 41'($signed(`AIPS_UNDER_BIP_A));
        if (format_b) begin
            over_lim  = 41'($signed(`AIPS_OVER_B));
            under_lim = (range == aips_pkg::AIPS_RANGE_UNI10) ? 41'($signed(`AIPS_UNDER_UNI_B))
                                                               : 41'($signed(`AIPS_UNDER_BIP_B));
        end
        product = 41'(sample_raw * $signed({1'b0, full_scale}));
        scaled  = product >>> `AIPS_RAW_SHIFT;
        if (scaled > over_lim) begin
            scaled = over_lim;
        end else if (scaled < under_lim) begin
            scaled = under_lim;
        end
        case (range)
            aips_pkg::AIPS_RANGE_OFF:    next_value = `AIPS_VALUE_OFF;
            aips_pkg::AIPS_RANGE_UNI10,
            aips_pkg::AIPS_RANGE_BIP10,
            aips_pkg::AIPS_RANGE_BIP80M: next_value = scaled[15:0];
            // other ranges arrive already in engineering units
            default:                     next_value = sample_raw[15:0];
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            value <= `AIPS_VALUE_OFF;
        end else if (sample_valid || range == aips_pkg::AIPS_RANGE_OFF) begin
            value <= next_value;
        end
    end
endmodule

// file: sim/aips_top_properties.sv
// port-level checker for the parameter decoding and scaling block
// assumes it is bound to aips_top and sees only its ports
`timescale 1ns/1ps

module aips_top_properties (
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        rst_n,
    // record writes and value reads
    input wire logic        param_wr,
    input wire logic [4:0]  param_addr,
    input wire logic [7:0]  param_wdata,
    input wire logic [15:0] in_rdata,
    // front end and status
    input wire logic [3:0]  open_wire_detect,
    input wire logic [3:0]  channel_active,
    input wire logic [7:0]  temperature_unit,
    input wire logic [7:0]  mains_rejection,
    input wire logic [3:0]  open_wire,
    input wire logic [3:0]  limit_over,
    input wire logic [3:0]  limit_under,
    input wire logic        diag_irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    chk_chan_off: assert property (
        param_wr && param_addr == 5'h08 && param_wdata == 8'hFF |=> !channel_active[0])
        else $error("channel 0 still active after code FF");
    chk_chan_on: assert property (
        param_wr && param_addr == 5'h08 && param_wdata != 8'hFF |=> channel_active[0])
        else $error("channel 0 inactive after a range code");
    chk_unit_copy: assert property (
        param_wr && param_addr == 5'h04 |=> temperature_unit == $past(param_wdata))
        else $error("unit fields differ from written byte");
    chk_mains_code: assert property (
        param_wr && param_addr == 5'h05 |=> mains_rejection[1:0] == $past(param_wdata[1:0])
        || ($past(param_wdata[1:0]) == 2'h0 && mains_rejection[1:0] == 2'h2))
        else $error("channel 0 rejection code wrong");
    chk_wire_cause: assert property (
        (open_wire & ~$past(open_wire_detect)) == 4'h0)
        else $error("open wire flagged without detection");
    chk_irq_cause: assert property (
        diag_irq |-> (open_wire & ~$past(open_wire)) != 4'h0)
        else $error("diagnostic pulse without open wire");
    chk_limit_quiet: assert property (
        param_wr && param_addr == 5'h02 && param_wdata == 8'h00 ##1 !param_wr [*2]
        |=> limit_over == 4'h0 && limit_under == 4'h0)
        else $error("limit flag while monitoring is off");
    chk_reset_state: assert property (@(posedge ref_clk) disable iff (1'b0)
        !rst_n |=> channel_active == 4'hF && mains_rejection == 8'h02 && in_rdata == 16'h0)
        else $error("state after reset wrong");

    cover property (diag_irq);
    cover property (limit_over != 4'h0);
    cover property (channel_active != 4'hF);
endmodule

// file: sim/aips_host_model.sv
// host controller model: writes record bytes, reads record bytes and values
// assumes strobes are taken on the rising edge of ref_clk
`timescale 1ns/1ps

module aips_host_model (
    // clock
    input  wire logic        ref_clk,
    // record access
    output logic             param_wr,
    output logic             param_rd,
    output logic [4:0]       param_addr,
    output logic [7:0]       param_wdata,
    input  wire logic [7:0]  param_rdata,
    // input area
    output logic             in_rd,
    output logic [2:0]       in_addr,
    input  wire logic [15:0] in_rdata
);
    initial begin
        {param_wr, param_rd, in_rd} = 3'h0;
        param_addr = 5'h00;
        param_wdata = 8'h00;
        in_addr = 3'h0;
    end

    // only while stopped: the bench sends records with the run idle
    task automatic write_byte(input logic [4:0] addr, input logic [7:0] data);
        @(posedge ref_clk);
        param_wr <= 1'b1;
        param_addr <= addr;
        param_wdata <= data;
        @(posedge ref_clk);
        param_wr <= 1'b0;
        // a released data line must not keep the old byte
        param_wdata <= ~data;
        #1;
    endtask

    task automatic read_byte(input logic [4:0] addr, output logic [7:0] data);
        @(posedge ref_clk);
        param_rd <= 1'b1;
        param_addr <= addr;
        @(posedge ref_clk);
        param_rd <= 1'b0;
        #1;
        data = param_rdata;
    endtask

    task automatic read_word(input logic [2:0] addr, output logic [15:0] data);
        @(posedge ref_clk);
        in_rd <= 1'b1;
        in_addr <= addr;
        @(posedge ref_clk);
        in_rd <= 1'b0;
        #1;
        data = in_rdata;
    endtask
endmodule

// file: sim/aips_top_tb.sv
// self-checking bench for the parameter decoding and scaling block
// assumes the host model drives the record bus and this module the front end
`timescale 1ns/1ps

module aips_top_tb;
    logic ref_clk, rst_n, param_wr, param_rd, in_rd, diag_irq;
    logic [4:0] param_addr;
    logic [7:0] param_wdata, param_rdata, temperature_unit, mains_rejection, rd8;
    logic [2:0] in_addr;
    logic [15:0] in_rdata, got;
    logic [3:0] sample_valid, open_wire_detect, channel_active, open_wire;
    logic [3:0] limit_over, limit_under;
    logic [95:0] sample_raw;
    int mismatches, total_checks;
    logic [7:0] fn_tab [6] = '{8'h10, 8'h20, 8'h12, 8'h22, 8'h11, 8'h21};
    logic [23:0] raw_tab [4] = '{24'h400000, 24'h7FFFFF, 24'h800000, 24'hC00000};
    logic [4:0] ra_tab [12] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05,
                                5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D};
    logic [7:0] rv_tab [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02,
                                8'h10, 8'h02, 8'h7F, 8'hFF, 8'h80, 8'h00};

    aips_top dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .param_wr(param_wr),
        .param_rd(param_rd), .param_addr(param_addr), .param_wdata(param_wdata),
        .param_rdata(param_rdata), .in_rd(in_rd), .in_addr(in_addr), .in_rdata(in_rdata),
        .sample_valid(sample_valid), .sample_raw(sample_raw),
        .open_wire_detect(open_wire_detect), .channel_active(channel_active),
        .temperature_unit(temperature_unit), .mains_rejection(mains_rejection),
        .open_wire(open_wire), .limit_over(limit_over), .limit_under(limit_under),
        .diag_irq(diag_irq));
    aips_host_model host_u (.ref_clk(ref_clk), .param_wr(param_wr), .param_rd(param_rd),
        .param_addr(param_addr), .param_wdata(param_wdata), .param_rdata(param_rdata),
        .in_rd(in_rd), .in_addr(in_addr), .in_rdata(in_rdata));

    initial ref_clk = 1'b0;
    always #12.5 ref_clk = ~ref_clk;

    // expected scaled word: floor of raw times full scale over 2^22, then clamped
    function automatic logic [15:0] scale(input logic [7:0] fn, input logic [23:0] raw);
        longint fs, hi, lo, d;
        fs = fn[5] ? 16384 : 27648;
        hi = fn[5] ? 20480 : 32511;
        lo = (fn[1] | fn[0]) ? (fn[5] ? -20480 : -32512) : (fn[5] ? -3277 : -4864);
        d = (longint'(signed'(raw)) * fs) >>> 22;
        if (d > hi) d = hi;
        if (d < lo) d = lo;
        return d[15:0];
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("checks=%0d mismatches=%0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic drive(input logic [3:0] mask, input logic [95:0] raw);
        @(posedge ref_clk);
        sample_valid <= mask;
        sample_raw <= raw;
        @(posedge ref_clk);
        sample_valid <= 4'h0;
        sample_raw <= ~raw;
        #1;
    endtask

    // bounded watch for the diagnostic pulse; a missing pulse ends the run
    task automatic wait_irq(input logic want);
        logic seen;
        seen = 1'b0;
        repeat (6) begin
            @(posedge ref_clk);
            #1;
            seen = seen | diag_irq;
        end
        check({15'h0, seen}, {15'h0, want});
        if (want && seen !== 1'b1) final_report();
    endtask

    initial begin
        rst_n = 1'b0;
        sample_valid = 4'h0;
        sample_raw = 96'h0;
        open_wire_detect = 4'h0;
        mismatches = 0;
        total_checks = 0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            host_u.read_byte(ra_tab[i], rd8);
            check({8'h00, rd8}, {8'h00, rv_tab[i]});
        end
        for (int f = 0; f < 6; f++) begin
            host_u.write_byte(5'h08, fn_tab[f]);
            for (int r = 0; r < 4; r++) begin
                drive(4'h1, {72'h0, raw_tab[r]});
                host_u.read_word(3'h0, got);
                check(got, scale(fn_tab[f], raw_tab[r]));
            end
        end
        host_u.write_byte(5'h08, 8'h10);
        drive(4'hF, {24'h400000, 24'h300000, 24'h200000, 24'h100000});
        for (int n = 0; n < 4; n++) begin
            host_u.read_word(3'(2 * n), got);
            check(got, 16'(6912 * (n + 1)));
        end
        host_u.write_byte(5'h08, 8'hFF);
        check({12'h0, channel_active}, 16'h000E);
        drive(4'h1, {72'h0, 24'h400000});
        host_u.read_word(3'h0, got);
        check(got, 16'h0000);
        host_u.write_byte(5'h08, 8'h10);
        host_u.write_byte(5'h04, 8'h24);
        check({8'h00, temperature_unit}, 16'h0024);
        host_u.write_byte(5'h14, 8'h50);
        host_u.write_byte(5'h05, 8'hC4);
        check({8'h00, mains_rejection}, 16'h00E4);
        // temperature codes pass the front-end word through unscaled
        drive(4'h4, {24'h0, 24'h001234, 48'h0});
        host_u.read_word(3'h4, got);
        check(got, 16'h1234);
        host_u.write_byte(5'h00, 8'h40);
        host_u.write_byte(5'h01, 8'hF5);
        @(posedge ref_clk);
        open_wire_detect <= 4'hF;
        wait_irq(1'b1);
        check({12'h0, open_wire}, 16'h0004);
        @(posedge ref_clk);
        open_wire_detect <= 4'h0;
        host_u.write_byte(5'h00, 8'h00);
        repeat (3) @(posedge ref_clk);
        open_wire_detect <= 4'hF;
        wait_irq(1'b0);
        host_u.write_byte(5'h02, 8'h01);
        host_u.write_byte(5'h0A, 8'h10);
        host_u.write_byte(5'h0B, 8'h00);
        drive(4'h1, {72'h0, 24'h400000});
        repeat (2) @(posedge ref_clk);
        #1;
        check({4'h0, limit_over, 4'h0, limit_under}, 16'h0100);
        // lower limit raised above the value: both flags up
        host_u.write_byte(5'h0C, 8'h7F);
        repeat (2) @(posedge ref_clk);
        #1;
        check({4'h0, limit_over, 4'h0, limit_under}, 16'h0101);
        host_u.write_byte(5'h02, 8'h00);
        repeat (3) @(posedge ref_clk);
        #1;
        check({8'h0, limit_over, limit_under}, 16'h0000);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        @(posedge ref_clk);
        rst_n <= 1'b1;
        #1;
        check({8'h00, mains_rejection}, 16'h0002);
        final_report();
    end
endmodule

bind aips_top aips_top_properties chk_u (.ref_clk(ref_clk), .rst_n(rst_n),
    .param_wr(param_wr), .param_addr(param_addr), .param_wdata(param_wdata),
    .in_rdata(in_rdata), .open_wire_detect(open_wire_detect),
    .channel_active(channel_active), .temperature_unit(temperature_unit),
    .mains_rejection(mains_rejection), .open_wire(open_wire), .limit_over(limit_over),
    .limit_under(limit_under), .diag_irq(diag_irq));
